// ---- core/ctm_cost_table.sv ----
// Cost lookup: base figure per operation plus operand address computation.
module ctm_cost_table (
	// Request
	input  ctm_pkg::ctm_op_t   op_i,
	input  ctm_pkg::ctm_ea_t   ea_mode_i,
	input  wire logic          long_i,
	// Costs
	output ctm_pkg::ctm_cost_t ea_o,
	output ctm_pkg::ctm_cost_t cost_o
);
	import ctm_pkg::*;

	function automatic ctm_cost_t base_of(input ctm_op_t op);
		unique case (op)
			OP_SHORT_REG:                      base_of = C_SHORT_REG;
			OP_EXG, OP_STATE_TO_REG:           base_of = C_EXG;
			OP_LINK:                           base_of = C_LINK;
			OP_UNLK:                           base_of = C_UNLK;
			OP_IMM_TO_STATE:                   base_of = C_IMM_STATE;
			OP_MOVE_TO_STATE:                  base_of = C_TO_STATE;
			OP_STATE_TO_MEM:                   base_of = C_STATE_TO_M;
			OP_PULSE_RESET:                    base_of = C_PULSE_RST;
			OP_STOP:                           base_of = C_STOP;
			OP_STATE_RETURN:                   base_of = C_STATE_RET;
			OP_SUB_RETURN:                     base_of = C_SUB_RET;
			OP_PERIPH_WORD_W:                  base_of = C_PER_WORD_W;
			OP_PERIPH_WORD_R:                  base_of = C_PER_WORD_R;
			OP_PERIPH_LONG_W:                  base_of = C_PER_LONG_W;
			OP_PERIPH_LONG_R:                  base_of = C_PER_LONG_R;
			OP_BCC_TAKEN:                      base_of = C_BCC_TAKEN;
			OP_BCC_NT_BYTE:                    base_of = C_BCC_NT_BYT;
			OP_BCC_NT_WORD:                    base_of = C_BCC_NT_WRD;
			OP_EXC_BUS, OP_EXC_ADDR:           base_of = C_EXC_BUS;
			OP_EXC_CHK:                        base_of = C_EXC_CHK;
			OP_EXC_DIVZ:                       base_of = C_EXC_DIVZ;
			OP_EXC_INT:                        base_of = C_EXC_INT;
			OP_EXC_TRAP:                       base_of = C_EXC_TRAP;
			OP_EXC_TRAPV:                      base_of = C_EXC_TRAPV;
			OP_EXC_RESET:                      base_of = C_EXC_RESET;
			default:                           base_of = C_ZERO;
		endcase
	endfunction

	function automatic ctm_cost_t ea_of(input ctm_ea_t m, input logic lng);
		unique case (m)
			EA_DREG, EA_AREG:                    ea_of = C_ZERO;
			EA_IND, EA_POSTINC, EA_IMM:          ea_of = lng ? EA_IND_L : EA_IND_W;
			EA_PREDEC:                           ea_of = lng ? EA_PRE_L : EA_PRE_W;
			EA_DISP16, EA_ABS_W, EA_PC_DISP:     ea_of = lng ? EA_DSP_L : EA_DSP_W;
			EA_INDEX, EA_PC_INDEX:               ea_of = lng ? EA_IDX_L : EA_IDX_W;
			EA_ABS_L:                            ea_of = lng ? EA_ABSL_L : EA_ABSL_W;
			default:                             ea_of = C_ZERO;
		endcase
	endfunction

	// Single-operand state moves always compute a word operand.
	wire word_ea = (op_i == OP_MOVE_TO_STATE) || (op_i == OP_STATE_TO_MEM);
	wire size_ea = (op_i == OP_EXC_CHK) || (op_i == OP_EXC_DIVZ);
	wire ctm_cost_t ea_any = ea_of(ea_mode_i, size_ea & long_i);

	assign ea_o   = (word_ea || size_ea) ? ea_any : C_ZERO;
	assign cost_o = cost_add(base_of(op_i), ea_o);
endmodule

// ---- core/ctm_pin_sync.sv ----
// Three-stage synchroniser whose output follows once stages two and three agree.
module ctm_pin_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and control
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	// Pins and clean levels
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire  [W-1:0] agree = ~(s2 ^ s3);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1      <= RST_VAL;
			s2      <= RST_VAL;
			s3      <= RST_VAL;
			level_o <= RST_VAL;
		end else if (ce_i) begin
			s1      <= pin_i;
			s2      <= s1;
			s3      <= s2;
			level_o <= (agree & s3) | (~agree & level_o);
		end
	end
endmodule

// ---- core/ctm_timing_core.sv ----
// Cycle-timing sequencer: plays out the periods, reads and writes of one operation.
//
// Behaviour
// - Nominal bus cycle lasts four clock periods.
// - Responder stretches add wait periods to total.
// - Each figure gives periods, reads and writes.
// - Total covers fetches and stores of operation.
// - Periods outside bus cycles keep bus idle.
// - Marked operations add address computation cost.
// - Address computation never performs a write.
// - Indirect/postincrement: 4(1/0) short, 8(2/0) long.
// - Predecrement: 6(1/0) short, 10(2/0) long.
// - Displacement/absolute short: 8(2/0), 12(3/0).
// - Indexed: 10(2/0) short, 14(3/0) long.
// - Index register size never changes timing.
// - Absolute long 12(3/0)/16(4/0); register zero.
// - Reset pulse 136(2/0), stop 4(0/0), return 40(10/0).
// - Exceptions include stacking, vector, first fetch.
// - Bus/address error 94(8/14); interrupt 72(9/6).
// - Reset exit 64(12/0) after both inputs negated.
// - Taken conditional branch costs 18(4/0).
module ctm_timing_core (
	// Clock, reset and enable
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  ce_i,
	// Operation request
	input  wire logic                  start_i,
	input  ctm_pkg::ctm_op_t           op_i,
	input  ctm_pkg::ctm_ea_t           ea_mode_i,
	input  wire logic                  long_i,
	// Asynchronous pins
	input  wire logic                  bus_ack_i,
	input  wire logic                  ext_reset_n_i,
	input  wire logic                  ext_halt_n_i,
	// Status and bus activity
	output logic                       ready_o,
	output logic                       busy_o,
	output logic                       bus_rd_o,
	output logic                       bus_wr_o,
	output logic                       done_o,
	output logic [ctm_pkg::CNT_W-1:0]  periods_o,
	output logic [ctm_pkg::CNT_W-1:0]  reads_o,
	output logic [ctm_pkg::CNT_W-1:0]  writes_o,
	output logic [ctm_pkg::CNT_W-1:0]  waits_o
);
	import ctm_pkg::*;

	// ********************************
	// Pin synchronisation
	// ********************************
	logic ack_s;
	logic rstn_s;
	logic haltn_s;

	ctm_pin_sync #(
		.W       (3),
		.RST_VAL (3'h0)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.pin_i     ({bus_ack_i, ext_reset_n_i, ext_halt_n_i}),
		.level_o   ({ack_s, rstn_s, haltn_s})
	);

	// ********************************
	// State
	// ********************************
	ctm_state_t      state;
	ctm_state_t      next_state;
	ctm_cost_t       exp_cost;
	logic [RW_W-1:0] rem_r;
	logic [RW_W-1:0] rem_w;
	logic [N_W-1:0]  rem_i;
	logic [1:0]      phase;

	// ********************************
	// Decode
	// ********************************
	wire is_bus  = (state == S_READ) || (state == S_WRITE);
	wire active  = is_bus || (state == S_INT);
	wire take    = (state == S_IDLE) && start_i;
	// Exit once both inputs read negated.
	wire rst_exit = (state == S_WAIT_RST) && rstn_s && haltn_s;
	wire abort   = !rstn_s && (state != S_WAIT_RST);
	wire load    = !abort && (take || rst_exit);
	wire at_last = is_bus && (phase == PHASE_LAST);
	wire cyc_end = at_last && ack_s;
	// Missing acknowledge holds the last period.
	wire stall   = at_last && !ack_s;

	ctm_op_t   op_sel;
	ctm_cost_t cost_sel;
	ctm_cost_t ea_cost;

	assign op_sel = rst_exit ? OP_EXC_RESET : op_i;

	// Reset exit shares the table so the reset figure comes from one place.
	ctm_cost_table u_table (
		.op_i      (op_sel),
		.ea_mode_i (ea_mode_i),
		.long_i    (long_i),
		.ea_o      (ea_cost),
		.cost_o    (cost_sel)
	);

	wire [N_W-1:0]  load_idle = idle_of(cost_sel);
	wire [RW_W-1:0] r_after   = (state == S_READ && cyc_end) ? RW_W'(rem_r - 1'b1) : rem_r;
	wire [RW_W-1:0] w_after   = (state == S_WRITE && cyc_end) ? RW_W'(rem_w - 1'b1) : rem_w;
	wire [N_W-1:0]  i_after   = (state == S_INT) ? N_W'(rem_i - 1'b1) : rem_i;
	wire            step      = cyc_end || (state == S_INT);

	always_comb begin
		next_state = state;
		if (abort) begin
			next_state = S_WAIT_RST;
		end else if (load) begin
			next_state = seq_next(cost_sel.r, cost_sel.w, load_idle);
		end else if (active && step) begin
			next_state = seq_next(r_after, w_after, i_after);
		end
	end

	wire finish = active && !abort && (next_state == S_IDLE);

	// ********************************
	// Sequencer registers
	// ********************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state    <= S_WAIT_RST;
			exp_cost <= C_ZERO;
			rem_r    <= '0;
			rem_w    <= '0;
			rem_i    <= '0;
			phase    <= '0;
		end else if (ce_i) begin
			state <= next_state;
			if (load) begin
				// Keep the full figure for the whole run.
				exp_cost <= cost_sel;
				rem_r    <= cost_sel.r;
				rem_w    <= cost_sel.w;
				// Leftover periods run with bus idle.
				rem_i    <= load_idle;
				phase    <= '0;
			end else begin
				rem_r <= r_after;
				rem_w <= w_after;
				rem_i <= i_after;
				phase <= (cyc_end || !is_bus) ? 2'h0 : (stall ? phase : 2'(phase + 2'h1));
			end
		end
	end

	// ********************************
	// Counters and outputs
	// ********************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			periods_o <= '0;
			reads_o   <= '0;
			writes_o  <= '0;
			waits_o   <= '0;
		end else if (ce_i) begin
			if (load) begin
				periods_o <= '0;
				reads_o   <= '0;
				writes_o  <= '0;
				waits_o   <= '0;
			end else if (active) begin
				// One count per period, waits included.
				periods_o <= CNT_W'(periods_o + 1'b1);
				// Every fetch and store is tallied.
				if (cyc_end && state == S_READ) begin
					reads_o <= CNT_W'(reads_o + 1'b1);
				end
				if (cyc_end && state == S_WRITE) begin
					writes_o <= CNT_W'(writes_o + 1'b1);
				end
				if (stall) begin
					waits_o <= CNT_W'(waits_o + 1'b1);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ready_o  <= 1'b0;
			busy_o   <= 1'b0;
			bus_rd_o <= 1'b0;
			bus_wr_o <= 1'b0;
			done_o   <= 1'b0;
		end else if (ce_i) begin
			ready_o  <= next_state == S_IDLE;
			busy_o   <= (next_state == S_READ) || (next_state == S_WRITE) || (next_state == S_INT);
			bus_rd_o <= next_state == S_READ;
			bus_wr_o <= next_state == S_WRITE;
			done_o   <= finish;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i || !ce_i);

	property p_total;
		done_o |-> periods_o == CNT_W'(exp_cost.n) + waits_o;
	endproperty
	a_total: assert property (p_total) else $error("Total periods differ from figure plus waits.");

	property p_counts;
		done_o |-> (reads_o == CNT_W'(exp_cost.r)) && (writes_o == CNT_W'(exp_cost.w));
	endproperty
	a_counts: assert property (p_counts) else $error("Read or write count differs from figure.");

	property p_four;
		(cyc_end && !$past(stall)) |-> ($past(phase, 3) == 2'h0) && $past(is_bus, 3);
	endproperty
	a_four: assert property (p_four) else $error("Unstretched bus cycle not four periods.");

	property p_wait;
		stall |=> waits_o == CNT_W'($past(waits_o) + 1'b1);
	endproperty
	a_wait: assert property (p_wait) else $error("Wait period not counted.");

	property p_idle_bus;
		(state == S_INT) |-> !bus_rd_o && !bus_wr_o;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("Bus active during internal period.");

	property p_ea_nowrite;
		ea_cost.w == '0;
	endproperty
	a_ea_nowrite: assert property (p_ea_nowrite) else $error("Address computation has a write.");

	property p_stop;
		(load && op_i == OP_STOP && !rst_exit) |=> (state == S_INT)[*4] ##1 done_o;
	endproperty
	a_stop: assert property (p_stop) else $error("Halt-until-event not four idle periods.");

	property p_bus_err;
		(load && !rst_exit && (op_i == OP_EXC_BUS || op_i == OP_EXC_ADDR)) |=>
			exp_cost.n == C_EXC_BUS.n && exp_cost.r == C_EXC_BUS.r && exp_cost.w == C_EXC_BUS.w;
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("Bus error figure wrong.");

	property p_rst_exit;
		(rst_exit && !abort) |=> (exp_cost == C_EXC_RESET) && busy_o && bus_rd_o;
	endproperty
	a_rst_exit: assert property (p_rst_exit) else $error("Reset exit did not start reset sequence.");

	property p_done_idle;
		done_o |-> ready_o && !busy_o;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("Done raised while not idle.");

	property p_hold_last;
		stall |=> phase == PHASE_LAST;
	endproperty
	a_hold_last: assert property (p_hold_last) else $error("Stretched cycle left last period.");

	property p_read_tally;
		(state == S_READ && cyc_end) |=> reads_o == CNT_W'($past(reads_o) + 1'b1);
	endproperty
	a_read_tally: assert property (p_read_tally) else $error("Read cycle not tallied.");

	property p_write_tally;
		(state == S_WRITE && cyc_end) |=> writes_o == CNT_W'($past(writes_o) + 1'b1);
	endproperty
	a_write_tally: assert property (p_write_tally) else $error("Write cycle not tallied.");

	property p_abort;
		abort |=> (state == S_WAIT_RST) && !busy_o && !done_o;
	endproperty
	a_abort: assert property (p_abort) else $error("Reset pin did not abort the run.");

	property p_reg_free;
		(ea_mode_i == EA_DREG || ea_mode_i == EA_AREG) |-> ea_cost == C_ZERO;
	endproperty
	a_reg_free: assert property (p_reg_free) else $error("Register operand has a cost.");

	property p_branch;
		(load && !rst_exit && op_i == OP_BCC_TAKEN) |=> exp_cost == C_BCC_TAKEN;
	endproperty
	a_branch: assert property (p_branch) else $error("Taken branch figure wrong.");

	property p_int_ack;
		(load && !rst_exit && op_i == OP_EXC_INT) |=> exp_cost == C_EXC_INT;
	endproperty
	a_int_ack: assert property (p_int_ack) else $error("Interrupt figure wrong.");

	c_wait:     cover property (stall ##1 cyc_end);
	c_rst_exit: cover property (rst_exit);
	c_write:    cover property (done_o && writes_o != '0);
	c_abort:    cover property (abort);
	c_back:     cover property (done_o && take);
endmodule

// ---- include/ctm_pkg.sv ----
// Shared types, cost constants and helper functions of the cycle-timing model.
package ctm_pkg;

	// ********************************
	// Widths and bus timing
	// ********************************
	localparam int unsigned N_W    = 8;
	localparam int unsigned RW_W   = 5;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned CLK_MHZ = 20;
	localparam logic [N_W-1:0] BUS_CYC    = 8'h04;
	localparam logic [1:0]     PHASE_LAST = 2'(BUS_CYC - 8'h01);

	// ********************************
	// Types
	// ********************************
	typedef struct packed {
		logic [N_W-1:0]  n;
		logic [RW_W-1:0] r;
		logic [RW_W-1:0] w;
	} ctm_cost_t;

	typedef enum logic [2:0] {
		S_WAIT_RST = 3'h0,
		S_IDLE     = 3'h1,
		S_READ     = 3'h3,
		S_INT      = 3'h2,
		S_WRITE    = 3'h6
	} ctm_state_t;

	typedef enum logic [4:0] {
		OP_SHORT_REG, OP_EXG, OP_STATE_TO_REG, OP_LINK, OP_UNLK, OP_IMM_TO_STATE,
		OP_MOVE_TO_STATE, OP_STATE_TO_MEM, OP_PULSE_RESET, OP_STOP, OP_STATE_RETURN,
		OP_SUB_RETURN, OP_PERIPH_WORD_W, OP_PERIPH_WORD_R, OP_PERIPH_LONG_W, OP_PERIPH_LONG_R,
		OP_BCC_TAKEN, OP_BCC_NT_BYTE, OP_BCC_NT_WORD, OP_EXC_BUS, OP_EXC_ADDR, OP_EXC_CHK,
		OP_EXC_DIVZ, OP_EXC_INT, OP_EXC_TRAP, OP_EXC_TRAPV, OP_EXC_RESET
	} ctm_op_t;

	typedef enum logic [3:0] {
		EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP16,
		EA_INDEX, EA_ABS_W, EA_ABS_L, EA_PC_DISP, EA_PC_INDEX, EA_IMM
	} ctm_ea_t;

	// ********************************
	// Instruction and exception costs
	// ********************************
	localparam ctm_cost_t C_SHORT_REG  = '{n: 8'h08, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t C_EXG        = '{n: 8'h0A, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t C_LINK       = '{n: 8'h20, r: 5'h04, w: 5'h04};
	localparam ctm_cost_t C_UNLK       = '{n: 8'h18, r: 5'h06, w: 5'h00};
	localparam ctm_cost_t C_IMM_STATE  = '{n: 8'h20, r: 5'h06, w: 5'h00};
	localparam ctm_cost_t C_TO_STATE   = '{n: 8'h12, r: 5'h04, w: 5'h00};
	localparam ctm_cost_t C_STATE_TO_M = '{n: 8'h10, r: 5'h02, w: 5'h02};
	localparam ctm_cost_t C_PULSE_RST  = '{n: 8'h88, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t C_STOP       = '{n: 8'h04, r: 5'h00, w: 5'h00};
	localparam ctm_cost_t C_STATE_RET  = '{n: 8'h28, r: 5'h0A, w: 5'h00};
	localparam ctm_cost_t C_SUB_RET    = '{n: 8'h20, r: 5'h08, w: 5'h00};
	localparam ctm_cost_t C_PER_WORD_W = '{n: 8'h18, r: 5'h04, w: 5'h02};
	localparam ctm_cost_t C_PER_WORD_R = '{n: 8'h18, r: 5'h06, w: 5'h00};
	localparam ctm_cost_t C_PER_LONG_W = '{n: 8'h20, r: 5'h04, w: 5'h04};
	localparam ctm_cost_t C_PER_LONG_R = '{n: 8'h20, r: 5'h08, w: 5'h00};
	localparam ctm_cost_t C_BCC_TAKEN  = '{n: 8'h12, r: 5'h04, w: 5'h00};
	localparam ctm_cost_t C_BCC_NT_BYT = '{n: 8'h0C, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t C_BCC_NT_WRD = '{n: 8'h14, r: 5'h04, w: 5'h00};
	localparam ctm_cost_t C_EXC_BUS    = '{n: 8'h5E, r: 5'h08, w: 5'h0E};
	localparam ctm_cost_t C_EXC_CHK    = '{n: 8'h44, r: 5'h08, w: 5'h06};
	localparam ctm_cost_t C_EXC_DIVZ   = '{n: 8'h42, r: 5'h08, w: 5'h06};
	localparam ctm_cost_t C_EXC_INT    = '{n: 8'h48, r: 5'h09, w: 5'h06};
	localparam ctm_cost_t C_EXC_TRAP   = '{n: 8'h3E, r: 5'h08, w: 5'h06};
	localparam ctm_cost_t C_EXC_TRAPV  = '{n: 8'h42, r: 5'h0A, w: 5'h06};
	localparam ctm_cost_t C_EXC_RESET  = '{n: 8'h40, r: 5'h0C, w: 5'h00};
	localparam ctm_cost_t C_ZERO       = '{n: 8'h00, r: 5'h00, w: 5'h00};

	// ********************************
	// Operand address computation costs
	// ********************************
	localparam ctm_cost_t EA_IND_W   = '{n: 8'h04, r: 5'h01, w: 5'h00};
	localparam ctm_cost_t EA_IND_L   = '{n: 8'h08, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t EA_PRE_W   = '{n: 8'h06, r: 5'h01, w: 5'h00};
	localparam ctm_cost_t EA_PRE_L   = '{n: 8'h0A, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t EA_DSP_W   = '{n: 8'h08, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t EA_DSP_L   = '{n: 8'h0C, r: 5'h03, w: 5'h00};
	localparam ctm_cost_t EA_IDX_W   = '{n: 8'h0A, r: 5'h02, w: 5'h00};
	localparam ctm_cost_t EA_IDX_L   = '{n: 8'h0E, r: 5'h03, w: 5'h00};
	localparam ctm_cost_t EA_ABSL_W  = '{n: 8'h0C, r: 5'h03, w: 5'h00};
	localparam ctm_cost_t EA_ABSL_L  = '{n: 8'h10, r: 5'h04, w: 5'h00};

	// ********************************
	// Helpers
	// ********************************
	function automatic ctm_cost_t cost_add(input ctm_cost_t a, input ctm_cost_t b);
		cost_add.n = N_W'(a.n + b.n);
		cost_add.r = RW_W'(a.r + b.r);
		cost_add.w = RW_W'(a.w + b.w);
	endfunction

	// Periods not covered by bus cycles are spent with the bus idle.
	function automatic logic [N_W-1:0] idle_of(input ctm_cost_t c);
		logic [N_W-1:0] bus_p;
		bus_p = N_W'((N_W'(c.r) + N_W'(c.w)) * BUS_CYC);
		idle_of = N_W'(c.n - bus_p);
	endfunction

	// Reads first, then the internal periods, then the writes.
	function automatic ctm_state_t seq_next(input logic [RW_W-1:0] r, input logic [RW_W-1:0] w,
			input logic [N_W-1:0] i);
		if (r != '0) begin
			seq_next = S_READ;
		end else if (i != '0) begin
			seq_next = S_INT;
		end else if (w != '0) begin
			seq_next = S_WRITE;
		end else begin
			seq_next = S_IDLE;
		end
	endfunction

endpackage

// ---- sim/cpu_cycle_timing_model_tb.sv ----
// Self-checking testbench of the cycle-timing core with a responder model.
module cpu_cycle_timing_model_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ctm_pkg::*;

	logic             clk_i = 1'b0;
	logic             sys_rst = 1'b1;
	logic             start = 1'b0;
	logic             long_op = 1'b0;
	logic             ext_reset_n = 1'b0;
	logic             ext_halt_n = 1'b0;
	logic             slow = 1'b0;
	logic             ce = 1'b1;
	logic             bus_ack;
	ctm_op_t          op = OP_SHORT_REG;
	ctm_ea_t          ea = EA_DREG;
	logic             ready, busy, bus_rd, bus_wr, done;
	logic [CNT_W-1:0] periods, reads, writes, waits;
	int               err_total = 0;
	int               tests_run = 0;
	int               cyc = 0;

	always #25 clk_i = ~clk_i;

	ctm_timing_core i_ctm_timing_core (
		.clk_i(clk_i), .sys_rst_i(sys_rst), .ce_i(ce), .start_i(start), .op_i(op),
		.ea_mode_i(ea), .long_i(long_op), .bus_ack_i(bus_ack), .ext_reset_n_i(ext_reset_n),
		.ext_halt_n_i(ext_halt_n), .ready_o(ready), .busy_o(busy), .bus_rd_o(bus_rd),
		.bus_wr_o(bus_wr), .done_o(done), .periods_o(periods), .reads_o(reads),
		.writes_o(writes), .waits_o(waits)
	);

	ctm_bus_responder i_ctm_bus_responder (
		.clk_i(clk_i), .bus_rd_i(bus_rd), .bus_wr_i(bus_wr), .slow_i(slow), .bus_ack_o(bus_ack)
	);

	// ********************************
	// Checking and closing
	// ********************************
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	// A hung operation must not stall the run forever.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			err_total++;
			final_report();
		end
	end

	// Counts busy, read, write and idle periods until done; poke raises a refused start.
	task automatic measure(input bit poke, output int nb, output int nr, output int nw, output int ni);
		nb = 0;
		nr = 0;
		nw = 0;
		ni = 0;
		for (int k = 0; k < 2000 && done !== 1'b1; k++) begin
			nb += int'(busy === 1'b1);
			nr += int'(bus_rd === 1'b1);
			nw += int'(bus_wr === 1'b1);
			ni += int'(busy === 1'b1 && bus_rd !== 1'b1 && bus_wr !== 1'b1);
			start = poke && k == 3;
			@(negedge clk_i);
		end
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic run_op(input ctm_op_t o, input ctm_ea_t m, input logic lg, input int n, input int r,
			input int w, input bit poke);
		int nb, nr, nw, ni, wt;
		op = o;
		ea = m;
		long_op = lg;
		start = 1'b1;
		@(negedge clk_i);
		measure(poke, nb, nr, nw, ni);
		wt = slow ? int'(waits) : 0;
		chk("done", 16'(done), 16'h0001);
		chk("busy_periods", 16'(nb), 16'(n + wt));
		chk("periods", periods, 16'(n + wt));
		chk("read_periods", 16'(nr), 16'(4 * r + wt));
		chk("write_periods", 16'(nw), 16'(4 * w));
		chk("idle_periods", 16'(ni), 16'(n - 4 * (r + w)));
		chk("reads", reads, 16'(r));
		chk("writes", writes, 16'(w));
		chk("ready", 16'(ready), 16'h0001);
		if (!slow) begin
			chk("waits", waits, 16'h0000);
		end
	endtask

	// Raises the reset pin first; starts given while halted must be ignored.
	task automatic reset_exit();
		int nb, nr, nw, ni;
		ext_reset_n = 1'b1;
		op = OP_STOP;
		start = 1'b1;
		repeat (20) @(negedge clk_i);
		start = 1'b0;
		chk("busy_halted", 16'(busy), 16'h0000);
		ext_halt_n = 1'b1;
		measure(1'b0, nb, nr, nw, ni);
		chk("reset_periods", 16'(nb), 16'h0040);
		chk("reset_read_periods", 16'(nr), 16'h0030);
		chk("reset_reads", reads, 16'h000C);
		chk("reset_writes", writes, 16'h0000);
	endtask

	task automatic abort_run();
		int nd;
		nd = 0;
		op = OP_PULSE_RESET;
		start = 1'b1;
		@(negedge clk_i);
		start = 1'b0;
		repeat (10) @(negedge clk_i);
		ext_reset_n = 1'b0;
		ext_halt_n = 1'b0;
		repeat (12) begin
			@(negedge clk_i);
			nd += int'(done === 1'b1);
		end
		chk("abort_done", 16'(nd), 16'h0000);
		chk("abort_busy", 16'(busy), 16'h0000);
		reset_exit();
	endtask

	task automatic wait_states();
		slow = 1'b1;
		repeat (6) @(negedge clk_i);
		run_op(OP_SHORT_REG, EA_DREG, 1'b0, 8, 2, 0, 1'b0);
		chk("waits_seen", 16'(waits != 16'h0000), 16'h0001);
		// Six model periods plus the four-edge pin latency leave seven held periods.
		chk("waits_count", waits, 16'h0007);
		slow = 1'b0;
		repeat (6) @(negedge clk_i);
	endtask

	// A low enable must freeze the sequence and its counts.
	task automatic ce_hold();
		int nb, nr, nw, ni;
		op = OP_STOP;
		start = 1'b1;
		@(negedge clk_i);
		start = 1'b0;
		repeat (2) @(negedge clk_i);
		ce = 1'b0;
		repeat (5) @(negedge clk_i);
		chk("frozen_periods", periods, 16'h0002);
		chk("frozen_busy", 16'(busy), 16'h0001);
		ce = 1'b1;
		measure(1'b0, nb, nr, nw, ni);
		chk("resumed_busy", 16'(nb), 16'h0002);
		chk("resumed_periods", periods, 16'h0004);
	endtask

	initial begin
		repeat (8) @(negedge clk_i);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_i);
		reset_exit();
		run_op(OP_SHORT_REG, EA_DREG, 1'b0, 8, 2, 0, 1'b0);
		run_op(OP_EXG, EA_DREG, 1'b0, 10, 2, 0, 1'b0);
		run_op(OP_LINK, EA_DREG, 1'b0, 32, 4, 4, 1'b0);
		run_op(OP_UNLK, EA_DREG, 1'b0, 24, 6, 0, 1'b0);
		run_op(OP_IMM_TO_STATE, EA_DREG, 1'b0, 32, 6, 0, 1'b0);
		run_op(OP_PULSE_RESET, EA_DREG, 1'b0, 136, 2, 0, 1'b1);
		run_op(OP_STOP, EA_DREG, 1'b0, 4, 0, 0, 1'b0);
		run_op(OP_STATE_RETURN, EA_DREG, 1'b0, 40, 10, 0, 1'b0);
		run_op(OP_BCC_TAKEN, EA_DREG, 1'b0, 18, 4, 0, 1'b0);
		run_op(OP_EXC_BUS, EA_DREG, 1'b0, 94, 8, 14, 1'b0);
		run_op(OP_EXC_ADDR, EA_DREG, 1'b0, 94, 8, 14, 1'b0);
		run_op(OP_EXC_INT, EA_DREG, 1'b0, 72, 9, 6, 1'b0);
		run_op(OP_EXC_TRAP, EA_DREG, 1'b0, 62, 8, 6, 1'b0);
		run_op(OP_EXC_TRAPV, EA_DREG, 1'b0, 66, 10, 6, 1'b0);
		run_op(OP_STATE_TO_MEM, EA_IND, 1'b0, 20, 3, 2, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_DREG, 1'b0, 18, 4, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_AREG, 1'b0, 18, 4, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_IND, 1'b0, 22, 5, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_POSTINC, 1'b0, 22, 5, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_PREDEC, 1'b0, 24, 5, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_DISP16, 1'b0, 26, 6, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_ABS_W, 1'b0, 26, 6, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_INDEX, 1'b0, 28, 6, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_ABS_L, 1'b0, 30, 7, 0, 1'b0);
		run_op(OP_EXC_CHK, EA_POSTINC, 1'b1, 76, 10, 6, 1'b0);
		run_op(OP_EXC_CHK, EA_PREDEC, 1'b1, 78, 10, 6, 1'b0);
		run_op(OP_EXC_CHK, EA_ABS_W, 1'b1, 80, 11, 6, 1'b0);
		run_op(OP_EXC_CHK, EA_INDEX, 1'b1, 82, 11, 6, 1'b0);
		run_op(OP_EXC_CHK, EA_ABS_L, 1'b1, 84, 12, 6, 1'b0);
		run_op(OP_EXC_DIVZ, EA_INDEX, 1'b0, 76, 10, 6, 1'b0);
		run_op(OP_EXC_CHK, EA_DISP16, 1'b0, 76, 10, 6, 1'b0);
		run_op(OP_STATE_TO_REG, EA_DREG, 1'b0, 10, 2, 0, 1'b0);
		run_op(OP_SUB_RETURN, EA_DREG, 1'b0, 32, 8, 0, 1'b0);
		run_op(OP_PERIPH_WORD_W, EA_DREG, 1'b0, 24, 4, 2, 1'b0);
		run_op(OP_PERIPH_WORD_R, EA_DREG, 1'b0, 24, 6, 0, 1'b0);
		run_op(OP_PERIPH_LONG_W, EA_DREG, 1'b0, 32, 4, 4, 1'b0);
		run_op(OP_PERIPH_LONG_R, EA_DREG, 1'b0, 32, 8, 0, 1'b0);
		run_op(OP_BCC_NT_BYTE, EA_DREG, 1'b0, 12, 2, 0, 1'b0);
		run_op(OP_BCC_NT_WORD, EA_DREG, 1'b0, 20, 4, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_IMM, 1'b0, 22, 5, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_PC_DISP, 1'b0, 26, 6, 0, 1'b0);
		run_op(OP_MOVE_TO_STATE, EA_PC_INDEX, 1'b0, 28, 6, 0, 1'b0);
		wait_states();
		abort_run();
		ce_hold();
		run_op(OP_STOP, EA_DREG, 1'b0, 4, 0, 0, 1'b0);
		final_report();
	end
endmodule

// ---- sim/ctm_bus_responder.sv ----
// Model of the memory and peripherals that answer the core's bus cycles.
module ctm_bus_responder (
	// Clock
	input  wire logic clk_i,
	// Bus activity seen from the core
	input  wire logic bus_rd_i,
	input  wire logic bus_wr_i,
	// Response mode: low answers at once, high stalls each burst
	input  wire logic slow_i,
	// Acknowledge towards the core
	output logic      bus_ack_o
);
	import ctm_pkg::*;

	logic [3:0] hold = 4'h0;
	logic       active;

	assign active = bus_rd_i || bus_wr_i;

	// stretched bus cycles
	// A slow responder keeps acknowledge low for six periods at the start of each burst.
	// It drops acknowledge again once the bus goes idle, so a slow idle bus never looks ready.
	always_ff @(posedge clk_i) begin
		if (!active) begin
			hold <= 4'h0;
		end else if (hold != 4'h6) begin
			hold <= hold + 4'h1;
		end
	end

	assign bus_ack_o = !slow_i || (active && hold == 4'h6);
endmodule
